// ---- dv/pcg_gain_checker.sv ----
// port assertions of the pixel gain stage
`timescale 1ns/1ps
`default_nettype none
module pcg_gain_checker (
    input wire logic               i_clk,       // clock
    input wire logic               i_rst,       // reset
    input wire logic               i_ce,        // enable
    input wire logic               i_psel,      // apb
    input wire logic               i_penable,   // apb
    input wire logic               i_pwrite,    // apb
    input wire logic [11:0]        i_paddr,     // apb
    input wire logic [31:0]        o_prdata,    // apb
    input wire logic               o_pready,    // apb
    input wire logic               o_pslverr,   // apb
    input wire logic               i_pix_valid, // pixel in
    input wire logic               o_pix_ready, // pixel in
    input wire logic               o_vid_valid, // pixel out
    input wire logic               i_vid_ready, // pixel out
    input wire pcg_pkg::pcg_pix_t  o_vid_data,  // pixel out
    input wire pcg_pkg::pcg_chan_t o_vid_chan   // pixel out
);
    import pcg_pkg::*;
    logic [1:0] occ_q;
    logic [1:0] occ_d;
    // words held in the output buffer, tracked from the handshakes
    assign occ_d = occ_q + 2'(i_pix_valid && o_pix_ready) - 2'(o_vid_valid && i_vid_ready && i_ce);
    always_ff @(posedge i_clk) occ_q <= i_rst ? 2'h0 : occ_d;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    pready_ce_a: assert property (o_pready == i_ce)
        else $error("pready does not follow enable");
    unmap_err_a: assert property (i_psel && i_penable && i_paddr >= 12'h050 |-> o_pslverr && o_prdata == 0)
        else $error("unmapped access not refused");
    upper_zero_a: assert property (i_psel && !i_pwrite && i_paddr < 12'h050 |-> o_prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    take_out_a: assert property (i_pix_valid && o_pix_ready |=> o_vid_valid)
        else $error("taken pixel not offered next cycle");
    vid_hold_a: assert property (o_vid_valid && !(i_vid_ready && i_ce) |=> o_vid_valid && $stable(o_vid_data)
        && $stable(o_vid_chan)) else $error("stalled pixel changed");
    buf_count_a: assert property (o_vid_valid == (occ_q != 2'h0))
        else $error("output valid disagrees with buffer count");
    buf_full_a: assert property (occ_q == 2'h2 |-> !o_pix_ready)
        else $error("full buffer still takes pixels");
    reset_empty_a: assert property ($fell(i_rst) |-> !o_vid_valid ##1 !o_vid_valid [*1])
        else $error("buffer not empty after reset");
endmodule
`default_nettype wire

// ---- dv/pcg_gain_tb.sv ----
// self-checking bench of the pixel gain stage
`timescale 1ns/1ps
`default_nettype none
module pcg_gain_tb;
    import pcg_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst, i_ce, i_psel, i_penable, i_pwrite, i_vid_ready, slow;
    logic        o_pready, o_pslverr, pix_valid, o_pix_ready, o_vid_valid;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, seed, sd2;
    pcg_pix_t    pix_data, o_vid_data;
    pcg_chan_t   pix_chan, o_vid_chan;
    logic [11:0] exp_q[$];
    int          n_mismatch, num_checks, tol, g, lr, le, re, m8;
    int          cw[5] = '{3000, 200, -200, 101, -500};
    int          cx[5] = '{2000, 100, -100, 100, -300};

    always #5 i_clk = ~i_clk;

    pcg_gain u_pcg_gain (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .i_pix_valid(pix_valid), .i_pix_data(pix_data), .i_pix_chan(pix_chan),
        .o_pix_ready(o_pix_ready), .o_vid_valid(o_vid_valid), .i_vid_ready(i_vid_ready),
        .o_vid_data(o_vid_data), .o_vid_chan(o_vid_chan));
    pcg_pix_src u_pcg_pix_src (.i_clk(i_clk), .i_rst(i_rst), .i_ready(o_pix_ready), .i_slow(slow),
        .o_valid(pix_valid), .o_data(pix_data), .o_chan(pix_chan));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction

    function automatic int eff(input int c);
        return g + (c < 2 ? lr : -lr) + (c == 0 ? le : c == 1 ? -le : c == 2 ? re : -re);
    endfunction

    function automatic logic [9:0] px(input logic [9:0] p, input int db);
        int e;
        int mx;
        e = int'($floor(real'(p) * 10.0 ** (real'(db) / 2000.0)));
        mx = m8 != 0 ? 255 : 1023;
        if (m8 != 0) e = e / 4;
        return 10'(e > mx ? mx : e);
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic drain();
        for (int n = 0; exp_q.size() != 0; n++) begin
            if (n > 3000) begin
                n_mismatch++;
                end_of_test();
            end
            @(posedge i_clk);
        end
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pix(input logic [11:0] got, input logic [11:0] exp);
        int d;
        d = int'(got[9:0]) - int'(exp[9:0]);
        num_checks++;
        if ($isunknown(got) || got[11:10] !== exp[11:10] || d > tol || d < -tol) begin
            n_mismatch++;
            $display("BAD %0t pix got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input int wd, output logic [31:0] rd, output logic e);
        int n;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= 32'(wd);
        @(posedge i_clk);
        i_penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 100);
        rd = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (o_pready !== 1'b1) begin
            n_mismatch++;
            end_of_test();
        end
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [11:0] a, input int d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, input int d, input logic ee);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 0, r, e);
        chk_reg(r, {16'h0, 16'(d)});
        chk_reg({31'h0, e}, {31'h0, ee});
    endtask

    // formatter stalls and clock enable gaps at random
    always @(posedge i_clk) begin
        sd2 <= i_rst ? xs(32'h7f63a1b0) : xs(sd2);
        i_vid_ready <= i_rst | sd2[0] | sd2[1];
        i_ce <= i_rst | (|sd2[4:2]);
    end

    always @(posedge i_clk) begin
        if (!i_rst && i_ce && o_vid_valid && i_vid_ready) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("BAD %0t extra pix %h exp %h", $time, o_vid_data, 10'h0);
            end else
                chk_pix({o_vid_chan, o_vid_data}, exp_q.pop_front());
        end
    end

    initial begin
        i_rst = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 12'h0;
        i_pwdata = 32'h0;
        slow = 1'b0;
        seed = 32'h7f63a1b0;
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        for (int i = 0; i < 13; i++)
            rd(12'(i < 5 ? 4 * i : i < 9 ? 12 + 4 * i : 28 + 4 * i), 0, 1'b0);
        rd(12'h0f0, 0, 1'b1);
        wr(12'h0f0, 5);
        for (int i = 0; i < 5; i++) begin
            wr(12'(4 * (i % 4)), cw[i]);
            rd(12'(4 * (i % 4)), cx[i], 1'b0);
        end
        for (int it = 0; it < 8; it++) begin
            seed = xs(seed);
            g = it == 0 ? 0 : it < 3 ? 2000 : int'(seed % 2301) - 300;
            lr = it == 0 ? 0 : int'(seed[7:0] % 201) - 100;
            le = it == 0 ? 0 : int'(seed[15:8] % 201) - 100;
            re = it == 0 ? 0 : int'(seed[23:16] % 201) - 100;
            m8 = it == 2 ? 1 : it > 2 ? int'(seed[24]) : 0;
            tol = it == 0 ? 0 : 2;
            slow <= seed[25];
            wr(12'h000, g);
            wr(12'h004, lr);
            wr(12'h008, le);
            wr(12'h00c, re);
            wr(12'h010, m8);
            for (int c = 0; c < 4; c++)
                rd(12'(32 + 4 * c), eff(c), 1'b0);
            for (int k = 0; k < 12; k++) begin
                seed = xs(seed);
                u_pcg_pix_src.q.push_back(seed[11:0]);
                exp_q.push_back({seed[11:10], px(seed[9:0], eff(int'(seed[11:10])))});
            end
            drain();
        end
        // a full-scale left odd pixel at +20 dB global gain (left odd/even balance left as set) must saturate; after a clear the left odd count at 0x040 must read 1
        wr(12'h000, 2000);
        wr(12'h004, 0);
        wr(12'h010, 0);
        wr(12'h014, 1);
        for (int c = 0; c < 4; c++)
            rd(12'(64 + 4 * c), 0, 1'b0);
        u_pcg_pix_src.q.push_back(12'h3ff);
        exp_q.push_back(12'h3ff);
        drain();
        rd(12'h040, 1, 1'b0);
        end_of_test();
    end
endmodule

bind pcg_gain pcg_gain_checker u_pcg_gain_checker (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_pix_valid(i_pix_valid), .o_pix_ready(o_pix_ready), .o_vid_valid(o_vid_valid),
    .i_vid_ready(i_vid_ready), .o_vid_data(o_vid_data), .o_vid_chan(o_vid_chan));
`default_nettype wire

// ---- dv/pcg_pix_src.sv ----
// digitizer model offering queued pixels to the gain stage
`timescale 1ns/1ps
`default_nettype none
module pcg_pix_src (
    input  wire logic          i_clk,   // clock
    input  wire logic          i_rst,   // reset
    input  wire logic          i_ready, // pixel taken
    input  wire logic          i_slow,  // idle a cycle after a take
    output logic               o_valid, // pixel offered
    output pcg_pkg::pcg_pix_t  o_data,  // pixel
    output pcg_pkg::pcg_chan_t o_chan   // channel
);
    import pcg_pkg::*;
    logic [11:0] q[$];
    // idle data toggles so a stale value never passes for a pixel
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_valid <= 1'b0;
            o_data <= 10'h155;
            o_chan <= PCG_LEFT_ODD;
        end else if (!o_valid || i_ready) begin
            if (o_valid)
                void'(q.pop_front());
            if (q.size() != 0 && !(i_slow && o_valid)) begin
                o_valid <= 1'b1;
                o_data <= q[0][9:0];
                o_chan <= pcg_chan_t'(q[0][11:10]);
            end else begin
                o_valid <= 1'b0;
                o_data <= ~o_data;
            end
        end
    end
endmodule
`default_nettype wire

// ---- hw/pcg_defines.svh ----
// register offsets, field positions, reset values and arithmetic constants of the pixel gain stage
`ifndef PCG_DEFINES_SVH
`define PCG_DEFINES_SVH

`define PCG_OFS_GAIN      12'h000
`define PCG_OFS_LR_BAL    12'h004
`define PCG_OFS_LOE_BAL   12'h008
`define PCG_OFS_ROE_BAL   12'h00c
`define PCG_OFS_CTRL      12'h010
`define PCG_OFS_SAT_CLR   12'h014
`define PCG_OFS_EFF_BASE  12'h020
`define PCG_OFS_SAT_BASE  12'h040

`define PCG_CTRL_OUT8_BIT 0

`define PCG_GAIN_RST      16'sh0000
`define PCG_BAL_RST       16'sh0000
`define PCG_GAIN_MIN      (-16'sd300)
`define PCG_GAIN_MAX      16'sd2000
`define PCG_BAL_MIN       (-16'sd100)
`define PCG_BAL_MAX       16'sd100

`define PCG_LOG2_10_DIV20 32'sd27866
`define PCG_FRAC_BITS     24
`define PCG_MULT_FRAC     12
`define PCG_MAX_CODE10    14'h03ff
`define PCG_MAX_CODE8     14'h00ff

`endif

// ---- hw/pcg_exp2.sv ----
// converts a dB value in hundredths into a linear multiplier, unsigned with 12 fraction bits
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"
module pcg_exp2 (
    input  wire pcg_pkg::pcg_db_t   i_db,    // gain in 0.01 dB steps
    output pcg_pkg::pcg_mult_t      o_mult   // 10^(dB/20), q4.12
);
    import pcg_pkg::*;

    function automatic logic [17:0] pow2_tab(input logic [4:0] idx);
        case (idx)
            5'd0:    pow2_tab = 18'h10000;
            5'd1:    pow2_tab = 18'd68438;
            5'd2:    pow2_tab = 18'd71468;
            5'd3:    pow2_tab = 18'd74632;
            5'd4:    pow2_tab = 18'd77936;
            5'd5:    pow2_tab = 18'd81386;
            5'd6:    pow2_tab = 18'd84990;
            5'd7:    pow2_tab = 18'd88752;
            5'd8:    pow2_tab = 18'd92682;
            5'd9:    pow2_tab = 18'd96785;
            5'd10:   pow2_tab = 18'd101070;
            5'd11:   pow2_tab = 18'd105545;
            5'd12:   pow2_tab = 18'd110218;
            5'd13:   pow2_tab = 18'd115098;
            5'd14:   pow2_tab = 18'd120193;
            5'd15:   pow2_tab = 18'd125515;
            default: pow2_tab = 18'h20000;
        endcase
    endfunction

    // dB/20 * log2(10) as a power of two, split into integer and fraction
    wire logic signed [31:0] exp_q   = 32'(i_db) * `PCG_LOG2_10_DIV20;
    wire logic signed [7:0]  exp_int = exp_q[31:24];
    wire logic [3:0]         seg     = exp_q[23:20];
    wire logic [7:0]         rem     = exp_q[19:12];
    wire logic [17:0]        base    = pow2_tab({1'b0, seg});
    wire logic [17:0]        nxt     = pow2_tab(5'({1'b0, seg} + 5'd1));
    wire logic [25:0]        slope   = 26'(nxt - base) * 26'(rem);
    wire logic [17:0]        mant    = base + 18'(slope >> 8);
    // mantissa is q16; shift to q12 scaled by 2^exp_int (exp_int spans -1..3)
    wire logic [2:0]         shamt   = 3'(8'sd4 - exp_int);
    wire logic [17:0]        scaled  = mant >> shamt;

    assign o_mult = scaled[15:0];
endmodule
`default_nettype wire

// ---- hw/pcg_gain.sv ----
// digital per-channel gain stage for line-scan pixels with apb settings
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.svh"

// Notes on behaviour
// RQ1: global gain is accepted from -3.00 dB to +20.00 dB in 0.01 dB steps, writes beyond are clamped; the code clamps only their low 16 bits as signed.
// RQ2: each dB value is turned into a linear multiplier of ten to the power dB over twenty.
// RQ3: every pixel is multiplied digitally by its multiplier before it goes to the video output.
// RQ4: a setting of 0 dB is unity, the calibrated reference response.
// RQ5: pixels are handled as four channels, left odd, left even, right odd and right even, each with its own gain.
// RQ6: the global gain adds the same dB amount to all four channels.
// RQ7: left/right balance spans -1.00 to +1.00 dB in 0.01 dB steps and resets to 0 dB.
// RQ8: positive left/right balance raises both left channels and lowers both right ones, negative the reverse.
// RQ9: left odd/even balance spans -1.00 to +1.00 dB in 0.01 dB steps and resets to 0 dB.
// RQ10: positive left odd/even balance raises left odd and lowers left even, negative the reverse.
// RQ11: a channel's dB gain is global plus or minus each balance, summed in dB before conversion.
// RQ12: right odd/even balance spans -1.00 to +1.00 dB in 0.01 dB steps and resets to 0 dB.
// RQ13: positive right odd/even balance raises right odd and lowers right even, negative the reverse.
// RQ14: each product saturates at the largest code of the selected output width instead of wrapping.
module pcg_gain (
    input  wire logic                i_clk,        // pixel clock, 100 MHz
    input  wire logic                i_rst,        // synchronous reset, active high
    input  wire logic                i_ce,         // clock enable, freezes all state when low
    input  wire logic                i_psel,       // apb select
    input  wire logic                i_penable,    // apb access phase
    input  wire logic                i_pwrite,     // apb write
    input  wire logic [11:0]         i_paddr,      // apb byte address
    input  wire logic [31:0]         i_pwdata,     // apb write data
    output logic [31:0]              o_prdata,     // apb read data
    output logic                     o_pready,     // apb ready
    output logic                     o_pslverr,    // apb error on unmapped address
    input  wire logic                i_pix_valid,  // digitizer pixel valid
    input  wire pcg_pkg::pcg_pix_t   i_pix_data,   // digitized pixel value
    input  wire pcg_pkg::pcg_chan_t  i_pix_chan,   // sensor channel of the pixel
    output logic                     o_pix_ready,  // gain stage can take a pixel
    output logic                     o_vid_valid,  // output pixel valid
    input  wire logic                i_vid_ready,  // formatter takes the pixel
    output pcg_pkg::pcg_pix_t        o_vid_data,   // gained pixel value
    output pcg_pkg::pcg_chan_t       o_vid_chan    // channel of the output pixel
);
    import pcg_pkg::*;

    // settings in hundredths of a dB
    pcg_db_t    gain_q;
    pcg_db_t    gain_d;
    pcg_db_t    lr_q;
    pcg_db_t    lr_d;
    pcg_db_t    loe_q;
    pcg_db_t    loe_d;
    pcg_db_t    roe_q;
    pcg_db_t    roe_d;
    logic       out8_q;
    logic       out8_d;
    logic [15:0] sat_cnt_q [4];

    pcg_db_t    eff_db  [4];
    pcg_mult_t  eff_mul [4];

    function automatic pcg_db_t clamp(input logic [31:0] v, input pcg_db_t lo, input pcg_db_t hi);
        logic signed [15:0] s;
        s = v[15:0];
        if (s < lo) begin
            clamp = lo;
        end else if (s > hi) begin
            clamp = hi;
        end else begin
            clamp = s;
        end
    endfunction

    // ---------------- apb slave ----------------
    wire logic        acc      = i_psel && i_penable && i_ce;
    wire logic        wr_en    = acc && i_pwrite;
    wire logic        hit_gain = (i_paddr == `PCG_OFS_GAIN);
    wire logic        hit_lr   = (i_paddr == `PCG_OFS_LR_BAL);
    wire logic        hit_loe  = (i_paddr == `PCG_OFS_LOE_BAL);
    wire logic        hit_roe  = (i_paddr == `PCG_OFS_ROE_BAL);
    wire logic        hit_ctrl = (i_paddr == `PCG_OFS_CTRL);
    wire logic        hit_sclr = (i_paddr == `PCG_OFS_SAT_CLR);
    wire logic        hit_eff  = (i_paddr[11:4] == 8'(`PCG_OFS_EFF_BASE >> 4)) && (i_paddr[1:0] == 2'b00);
    wire logic        hit_sat  = (i_paddr[11:4] == 8'(`PCG_OFS_SAT_BASE >> 4)) && (i_paddr[1:0] == 2'b00);
    wire logic [1:0]  sel_ch   = i_paddr[3:2];
    wire logic        hit_any  = hit_gain || hit_lr || hit_loe || hit_roe || hit_ctrl || hit_sclr
                                 || hit_eff || hit_sat;
    wire logic        clr_sat  = wr_en && hit_sclr;

    // zero-wait slave: every access completes in its first access cycle while enabled
    assign o_pready  = i_ce;
    assign o_pslverr = i_psel && i_penable && !hit_any;

    always_comb begin
        o_prdata = 32'h0000_0000;
        if (i_psel && !i_pwrite) begin
            if (hit_gain) begin
                o_prdata = {16'h0000, gain_q};
            end else if (hit_lr) begin
                o_prdata = {16'h0000, lr_q};
            end else if (hit_loe) begin
                o_prdata = {16'h0000, loe_q};
            end else if (hit_roe) begin
                o_prdata = {16'h0000, roe_q};
            end else if (hit_ctrl) begin
                o_prdata = {31'h0000_0000, out8_q};
            end else if (hit_eff) begin
                o_prdata = {16'h0000, eff_db[sel_ch]};
            end else if (hit_sat) begin
                o_prdata = {16'h0000, sat_cnt_q[sel_ch]};
            end else begin
                o_prdata = 32'h0000_0000;
            end
        end
    end

    always_comb begin
        gain_d = gain_q;
        lr_d   = lr_q;
        loe_d  = loe_q;
        roe_d  = roe_q;
        out8_d = out8_q;
        if (wr_en) begin
            if (hit_gain) begin
                gain_d = clamp(i_pwdata, `PCG_GAIN_MIN, `PCG_GAIN_MAX); // RQ1
            end
            if (hit_lr) begin
                lr_d = clamp(i_pwdata, `PCG_BAL_MIN, `PCG_BAL_MAX); // RQ7
            end
            if (hit_loe) begin
                loe_d = clamp(i_pwdata, `PCG_BAL_MIN, `PCG_BAL_MAX); // RQ9
            end
            if (hit_roe) begin
                roe_d = clamp(i_pwdata, `PCG_BAL_MIN, `PCG_BAL_MAX); // RQ12
            end
            if (hit_ctrl) begin
                out8_d = i_pwdata[`PCG_CTRL_OUT8_BIT];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gain_q <= `PCG_GAIN_RST; // RQ4
            lr_q   <= `PCG_BAL_RST; // RQ7
            loe_q  <= `PCG_BAL_RST; // RQ9
            roe_q  <= `PCG_BAL_RST; // RQ12
            out8_q <= 1'b0;
        end else if (i_ce) begin
            gain_q <= gain_d;
            lr_q   <= lr_d;
            loe_q  <= loe_d;
            roe_q  <= roe_d;
            out8_q <= out8_d;
        end
    end

    // ---------------- per-channel gain in dB ----------------
    // sum stays within -5.00..+22.00 dB, well inside 16 bits
    assign eff_db[PCG_LEFT_ODD]   = gain_q + lr_q + loe_q; // RQ6 RQ8 RQ10 RQ11
    assign eff_db[PCG_LEFT_EVEN]  = gain_q + lr_q - loe_q; // RQ6 RQ8 RQ10 RQ11
    assign eff_db[PCG_RIGHT_ODD]  = gain_q - lr_q + roe_q; // RQ6 RQ8 RQ13 RQ11
    assign eff_db[PCG_RIGHT_EVEN] = gain_q - lr_q - roe_q; // RQ6 RQ8 RQ13 RQ11

    // ---------------- multiplier and saturation per channel ----------------
    pcg_stream_if up_s ();
    pcg_stream_if dn_s ();

    wire logic [13:0] max_code = out8_q ? `PCG_MAX_CODE8 : `PCG_MAX_CODE10;
    wire logic        take     = i_ce && i_pix_valid && up_s.ready;

    logic [3:0] ch_sat;

    for (genvar c = 0; c < 4; c++) begin : g_ch
        pcg_exp2 u_exp (
            .i_db   (eff_db[c]),
            .o_mult (eff_mul[c])
        ); // RQ2 RQ5

        wire logic [25:0] prod  = 26'(i_pix_data) * 26'(eff_mul[c]); // RQ3
        wire logic [13:0] whole = prod[25:`PCG_MULT_FRAC];
        wire logic [13:0] shown = out8_q ? (whole >> 2) : whole;
        assign ch_sat[c] = (shown > max_code);

        // the count keeps the hit that lands in the cycle it is cleared
        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                sat_cnt_q[c] <= 16'h0000;
            end else if (i_ce) begin
                if (take && ch_sat[c] && (i_pix_chan == 2'(c))) begin
                    sat_cnt_q[c] <= clr_sat ? 16'h0001
                                  : (sat_cnt_q[c] == 16'hffff ? sat_cnt_q[c] : sat_cnt_q[c] + 16'h0001);
                end else if (clr_sat) begin
                    sat_cnt_q[c] <= 16'h0000;
                end
            end
        end
    end

    logic [13:0] shown_sel;

    always_comb begin
        shown_sel = 14'h0000;
        case (i_pix_chan)
            PCG_LEFT_ODD:   shown_sel = out8_q ? (g_ch[0].whole >> 2) : g_ch[0].whole;
            PCG_LEFT_EVEN:  shown_sel = out8_q ? (g_ch[1].whole >> 2) : g_ch[1].whole;
            PCG_RIGHT_ODD:  shown_sel = out8_q ? (g_ch[2].whole >> 2) : g_ch[2].whole;
            PCG_RIGHT_EVEN: shown_sel = out8_q ? (g_ch[3].whole >> 2) : g_ch[3].whole;
            default:        shown_sel = 14'h0000;
        endcase
    end

    wire logic [13:0] limited = ch_sat[i_pix_chan] ? max_code : shown_sel; // RQ14

    assign up_s.valid  = i_pix_valid;
    assign up_s.data   = limited[9:0];
    assign up_s.chan   = i_pix_chan;
    assign o_pix_ready = up_s.ready;

    pcg_out_buf u_buf (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_ce  (i_ce),
        .in_s  (up_s),
        .out_s (dn_s)
    );

    assign dn_s.ready  = i_vid_ready;
    assign o_vid_valid = dn_s.valid;
    assign o_vid_data  = dn_s.data;
    assign o_vid_chan  = dn_s.chan;
endmodule
`default_nettype wire

// ---- hw/pcg_out_buf.sv ----
// two-entry valid/ready buffer in front of the video output
`timescale 1ns/1ps
`default_nettype none
module pcg_out_buf (
    input  wire logic   i_clk,   // pixel clock
    input  wire logic   i_rst,   // synchronous reset, active high
    input  wire logic   i_ce,    // clock enable
    pcg_stream_if.snk   in_s,    // from the gain stage
    pcg_stream_if.src   out_s    // to the video formatter
);
    import pcg_pkg::*;

    pcg_pix_t   mem_q [2];
    pcg_chan_t  chn_q [2];
    logic       wr_q;
    logic       rd_q;
    logic [1:0] cnt_q;

    wire logic push = i_ce && in_s.valid && in_s.ready;
    wire logic pop  = i_ce && out_s.valid && out_s.ready;

    assign in_s.ready  = i_ce && (cnt_q != 2'd2);
    assign out_s.valid = (cnt_q != 2'd0);
    assign out_s.data  = mem_q[rd_q];
    assign out_s.chan  = chn_q[rd_q];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_s.data;
                chn_q[wr_q] <= in_s.chan;
                wr_q        <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + 2'(push) - 2'(pop);
        end
    end
endmodule
`default_nettype wire

// ---- hw/pcg_pkg.sv ----
// shared types of the pixel gain stage
package pcg_pkg;
    typedef logic signed [15:0] pcg_db_t;
    typedef logic [15:0]        pcg_mult_t;
    typedef logic [9:0]         pcg_pix_t;
    typedef enum logic [1:0] {
        PCG_LEFT_ODD,
        PCG_LEFT_EVEN,
        PCG_RIGHT_ODD,
        PCG_RIGHT_EVEN
    } pcg_chan_t;
endpackage

// ---- hw/pcg_stream_if.sv ----
// valid/ready pixel stream between the gain stage and its output buffer
`timescale 1ns/1ps
`default_nettype none
interface pcg_stream_if;
    logic              valid;
    logic              ready;
    pcg_pkg::pcg_pix_t data;
    pcg_pkg::pcg_chan_t chan;
    modport src (output valid, output data, output chan, input ready);
    modport snk (input valid, input data, input chan, output ready);
endinterface
`default_nettype wire
